// file: chcfg_pkg.sv
// package for the channel configuration and mode register bank
// assumes a byte-wide register port driven by the serial interface logic
package chcfg_pkg;

    localparam int            NUM_CH            = 8;
    localparam logic [5:0]    SETUP_BASE        = 6'h28;
    localparam logic [5:0]    CTIME_BASE        = 6'h30;
    localparam logic [5:0]    MODE_BASE         = 6'h38;
    localparam logic [2:0]    BLOCK_SEL_SETUP   = 3'h5;
    localparam logic [2:0]    BLOCK_SEL_CTIME   = 3'h6;
    localparam logic [2:0]    BLOCK_SEL_MODE    = 3'h7;
    localparam logic [7:0]    SETUP_RESET       = 8'h00;
    localparam logic [7:0]    CTIME_RESET       = 8'h91;
    localparam logic [7:0]    MODE_RESET        = 8'h00;
    // byte address split: register block above, register index below
    localparam int            ADDR_BLK_HI       = 5;
    localparam int            ADDR_BLK_LO       = 3;
    localparam int            ADDR_IDX_HI       = 2;

    // channel setup fields
    localparam int            SU_BUF_OFF        = 7;
    localparam int            SU_CFG_HI         = 6;
    localparam int            SU_CFG_LO         = 5;
    localparam int            SU_STAT_OPT       = 4;
    localparam int            SU_ENABLE         = 3;
    localparam int            SU_RANGE_HI       = 2;
    localparam int            SU_RANGE_MID      = 1;
    localparam int            SU_RANGE_LO       = 0;
    // conversion time fields
    localparam int            CT_CHOP           = 7;
    localparam int            CT_WORD_HI        = 6;
    // mode fields
    localparam int            MD_SEL_HI         = 7;
    localparam int            MD_SEL_LO         = 5;
    localparam int            MD_CLK_OFF        = 4;
    localparam int            MD_STATUS_DATA    = 3;
    localparam int            MD_CONT_READ      = 2;
    localparam int            MD_WIDTH24        = 1;
    localparam int            MD_CLAMP          = 0;

    // conversion time arithmetic
    localparam logic [4:0]    CHOP_SHIFT        = 5'd7;
    localparam logic [4:0]    NOCHOP_SHIFT      = 5'd6;
    localparam logic [14:0]   CHOP_OFFSET       = 15'd248;
    localparam logic [14:0]   NOCHOP_OFFSET     = 15'd206;
    localparam logic [6:0]    CHOP_WORD_MIN     = 7'd2;
    localparam logic [6:0]    NOCHOP_WORD_MIN   = 7'd3;
    localparam logic [4:0]    WIDTH_24          = 5'd24;
    localparam logic [4:0]    WIDTH_16          = 5'd16;

    typedef enum logic [2:0] {
        MODE_IDLE      = 3'b000,
        MODE_CONT      = 3'b001,
        MODE_SINGLE    = 3'b010,
        MODE_STANDBY   = 3'b011,
        MODE_ADC_ZS    = 3'b100,
        MODE_RESERVED  = 3'b101,
        MODE_CH_ZS     = 3'b110,
        MODE_CH_FS     = 3'b111
    } mode_code_t;

    typedef enum logic [2:0] {
        RANGE_BI_1V25  = 3'b000,
        RANGE_UNI_1V25 = 3'b001,
        RANGE_BI_0V625 = 3'b010,
        RANGE_UNI_0V625= 3'b011,
        RANGE_BI_2V5   = 3'b100,
        RANGE_UNI_2V5  = 3'b101
    } range_code_t;

    // one-hot controller states
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_CONVERT = 4'b0010,
        ST_CAL     = 4'b0100,
        ST_HALT    = 4'b1000
    } run_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // decoded view of the active channel for the converter core
    typedef struct packed {
        logic        buf_off;
        logic        differential;
        logic [2:0]  pos_input;
        logic        neg_is_common;
        logic [2:0]  neg_input;
        logic        bipolar;
        logic [1:0]  range_step;
        logic        chop;
        logic [6:0]  filter_word;
        logic        filter_word_ok;
        logic [14:0] conv_cycles;
    } ch_cfg_t;

    typedef struct packed {
        logic        clock_output_off;
        logic        status_then_data;
        logic        continuous_read;
        logic [4:0]  data_width;
        logic        clamp;
    } mode_flags_t;

    // conversion time in master clock cycles
    function automatic logic [14:0] conv_time(input logic       chop,
                                              input logic [6:0] filt_word,
                                              input logic       multi);
        logic [14:0] base;
        base = chop ? ({8'h00, filt_word} << CHOP_SHIFT) + CHOP_OFFSET
                    : ({8'h00, filt_word} << NOCHOP_SHIFT) + NOCHOP_OFFSET;
        conv_time = base + {14'h0000, multi};
    endfunction : conv_time

endpackage : chcfg_pkg

// file: chcfg_decode.sv
// decodes one channel's setup and conversion-time bytes
// assumes inputs come straight from the register bank
`timescale 1ns/1ns
`default_nettype none
module chcfg_decode
    import chcfg_pkg::*;
(
    input  wire logic [2:0]   channel_i,
    input  wire logic [7:0]   setup_i,
    input  wire logic [7:0]   ctime_i,
    input  wire logic         multi_i,
    output chcfg_pkg::ch_cfg_t cfg_o
);
    logic [1:0] cfg_sel;
    logic [6:0] filt_word;

    always_comb
    begin
        cfg_sel                = {setup_i[SU_CFG_HI], setup_i[SU_CFG_LO]};
        filt_word              = ctime_i[CT_WORD_HI:0];
        cfg_o                  = '0;
        cfg_o.buf_off          = setup_i[SU_BUF_OFF];
        cfg_o.pos_input        = channel_i;
        cfg_o.neg_is_common    = 1'b1;
        if (cfg_sel == 2'b11)
        begin
            // channels n and n+4 share pair (2n mod 8, 2n+1 mod 8)
            cfg_o.differential  = 1'b1;
            cfg_o.neg_is_common = 1'b0;
            cfg_o.pos_input     = {channel_i[1:0], 1'b0};
            cfg_o.neg_input     = {channel_i[1:0], 1'b1};
        end
        cfg_o.bipolar          = ~setup_i[SU_RANGE_LO];
        cfg_o.range_step       = setup_i[SU_RANGE_HI] ? 2'd0
                                 : {1'b0, setup_i[SU_RANGE_MID]} + 2'd1;
        cfg_o.chop             = ctime_i[CT_CHOP];
        cfg_o.filter_word      = filt_word;
        cfg_o.filter_word_ok   = ctime_i[CT_CHOP] ? (filt_word >= CHOP_WORD_MIN)
                                                  : (filt_word >= NOCHOP_WORD_MIN);
        cfg_o.conv_cycles      = conv_time(ctime_i[CT_CHOP], filt_word, multi_i);
    end
endmodule : chcfg_decode
`default_nettype wire

// file: chcfg_regs.sv
// channel setup, conversion time and operating mode register bank
// assumes the serial interface gives one-cycle byte read/write strobes
// and the converter core reports ready flags and completion
`timescale 1ns/1ns
`default_nettype none
module chcfg_regs
    import chcfg_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire chcfg_pkg::reg_req_t   req_i,
    input  wire logic                  general_pin_one_i,
    input  wire logic [7:0]            ready_flags_i,
    input  wire logic                  conv_done_i,
    input  wire logic                  cal_done_i,
    output logic [7:0]                 rdata_o,
    output logic                       rvalid_o,
    output logic                       ready_n_o,
    output logic                       clear_status_o,
    output logic                       abort_o,
    output logic [2:0]                 mode_select_o,
    output logic [2:0]                 active_channel_o,
    output logic [7:0]                 scan_enable_o,
    output logic                       start_conv_o,
    output logic                       start_cal_o,
    output logic                       pin_or_ready_o,
    output chcfg_pkg::ch_cfg_t         active_cfg_o,
    output chcfg_pkg::mode_flags_t     mode_flags_o,
    output logic                       pair_read_o
);
    typedef struct packed {
        logic [NUM_CH-1:0][7:0] setup;
        logic [NUM_CH-1:0][7:0] ctime;
        logic [7:0]             mode;
        logic [2:0]             channel;
        run_state_t             state;
        logic [7:0]             rdata;
        logic                   rvalid;
        logic                   ready_n;
        logic                   clear_status;
        logic                   abort;
        logic                   start_conv;
        logic                   start_cal;
        logic                   pin_or_ready;
        logic [7:0]             scan_en;
        ch_cfg_t                cfg;
        mode_flags_t            flags;
        logic                   pair_read;
    } state_t;

    state_t     cur_r;
    state_t     cur_nxt;
    ch_cfg_t    dec_cfg;
    logic       multi;
    logic [2:0] blk;
    logic [2:0] idx;
    mode_code_t mcode;

    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'd0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            n = n + {3'b000, v[i]};
        end
        count_ones = n;
    endfunction : count_ones

    // more than one enabled channel only matters while scanning
    assign multi = (mode_code_t'(cur_r.mode[MD_SEL_HI:MD_SEL_LO]) == MODE_CONT)
                   && (count_ones(cur_r.scan_en) > 4'd1);
    assign blk   = req_i.addr[ADDR_BLK_HI:ADDR_BLK_LO];
    assign idx   = req_i.addr[ADDR_IDX_HI:0];
    assign mcode = mode_code_t'(req_i.wdata[MD_SEL_HI:MD_SEL_LO]);

    chcfg_decode u_decode (
        .channel_i (cur_r.channel),
        .setup_i   (cur_r.setup[cur_r.channel]),
        .ctime_i   (cur_r.ctime[cur_r.channel]),
        .multi_i   (multi),
        .cfg_o     (dec_cfg)
    );

    always_comb
    begin
        cur_nxt              = cur_r;
        cur_nxt.rvalid       = 1'b0;
        cur_nxt.clear_status = 1'b0;
        cur_nxt.abort        = 1'b0;
        cur_nxt.start_conv   = 1'b0;
        cur_nxt.start_cal    = 1'b0;

        if (req_i.wr)
        begin
            unique case (blk)
                BLOCK_SEL_SETUP: cur_nxt.setup[idx] = req_i.wdata;
                BLOCK_SEL_CTIME: cur_nxt.ctime[idx] = req_i.wdata;
                BLOCK_SEL_MODE:
                begin
                    cur_nxt.mode         = req_i.wdata;
                    cur_nxt.channel      = idx;
                    cur_nxt.clear_status = 1'b1;
                    cur_nxt.abort        = 1'b1;
                    cur_nxt.ready_n      = 1'b1;
                    unique case (mcode)
                        MODE_CONT, MODE_SINGLE:
                        begin
                            cur_nxt.state      = ST_CONVERT;
                            cur_nxt.start_conv = 1'b1;
                        end
                        MODE_ADC_ZS, MODE_CH_ZS, MODE_CH_FS:
                        begin
                            cur_nxt.state     = ST_CAL;
                            cur_nxt.start_cal = 1'b1;
                        end
                        MODE_STANDBY: cur_nxt.state = ST_HALT;
                        MODE_IDLE, MODE_RESERVED: cur_nxt.state = ST_IDLE;
                    endcase
                end
                default: ;
            endcase
        end
        // only a mode write overrides a done; other writes must not lose it
        if (!(req_i.wr && (blk == BLOCK_SEL_MODE)))
        begin
            unique case (cur_r.state)
                ST_CONVERT:
                begin
                    if (conv_done_i)
                    begin
                        cur_nxt.ready_n = 1'b0;
                        if (mode_code_t'(cur_r.mode[MD_SEL_HI:MD_SEL_LO]) == MODE_SINGLE)
                        begin
                            cur_nxt.state = ST_IDLE;
                        end
                    end
                end
                ST_CAL:
                begin
                    if (cal_done_i)
                    begin
                        cur_nxt.ready_n = 1'b0;
                        cur_nxt.state   = ST_IDLE;
                    end
                end
                ST_IDLE, ST_HALT: ;
                default: cur_nxt.state = ST_IDLE;
            endcase
        end

        if (req_i.rd)
        begin
            cur_nxt.rvalid = 1'b1;
            unique case (blk)
                BLOCK_SEL_SETUP: cur_nxt.rdata = cur_r.setup[idx];
                BLOCK_SEL_CTIME: cur_nxt.rdata = cur_r.ctime[idx];
                // every alias returns the one register; host uses the base
                BLOCK_SEL_MODE:  cur_nxt.rdata = cur_r.mode;
                default:         cur_nxt.rdata = 8'h00;
            endcase
        end

        for (int c = 0; c < NUM_CH; c++)
        begin
            cur_nxt.scan_en[c] = cur_nxt.setup[c][SU_ENABLE];
        end
        cur_nxt.pin_or_ready = cur_r.setup[cur_r.channel][SU_STAT_OPT]
                               ? general_pin_one_i
                               : ready_flags_i[cur_r.channel];
        cur_nxt.cfg = dec_cfg;
        cur_nxt.flags.clock_output_off = cur_r.mode[MD_CLK_OFF];
        cur_nxt.flags.status_then_data = cur_r.mode[MD_STATUS_DATA];
        cur_nxt.flags.continuous_read  = cur_r.mode[MD_CONT_READ];
        cur_nxt.flags.data_width = cur_r.mode[MD_WIDTH24] ? WIDTH_24 : WIDTH_16;
        cur_nxt.flags.clamp      = cur_r.mode[MD_CLAMP];
        // continuous read always pairs status and data
        cur_nxt.pair_read = cur_r.mode[MD_STATUS_DATA] | cur_r.mode[MD_CONT_READ];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur_r         <= '0;
            cur_r.setup   <= {NUM_CH{SETUP_RESET}};
            cur_r.ctime   <= {NUM_CH{CTIME_RESET}};
            cur_r.mode    <= MODE_RESET;
            cur_r.state   <= ST_IDLE;
            cur_r.ready_n <= 1'b1;
            cur_r.flags.data_width <= WIDTH_16;
            cur_r.cfg.chop <= CTIME_RESET[CT_CHOP];
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    assign rdata_o          = cur_r.rdata;
    assign rvalid_o         = cur_r.rvalid;
    assign ready_n_o        = cur_r.ready_n;
    assign clear_status_o   = cur_r.clear_status;
    assign abort_o          = cur_r.abort;
    assign mode_select_o    = cur_r.mode[MD_SEL_HI:MD_SEL_LO];
    assign active_channel_o = cur_r.channel;
    assign scan_enable_o    = cur_r.scan_en;
    assign start_conv_o     = cur_r.start_conv;
    assign start_cal_o      = cur_r.start_cal;
    assign pin_or_ready_o   = cur_r.pin_or_ready;
    assign active_cfg_o     = cur_r.cfg;
    assign mode_flags_o     = cur_r.flags;
    assign pair_read_o      = cur_r.pair_read;
endmodule : chcfg_regs
`default_nettype wire

// file: chcfg_regs_chk.sv
// checker on the register bank ports: mode writes, reads, mode flags
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module chcfg_regs_chk
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire chcfg_pkg::reg_req_t    req_i,
    input  wire logic [7:0]             rdata_o,
    input  wire logic                   rvalid_o,
    input  wire logic                   ready_n_o,
    input  wire logic                   clear_status_o,
    input  wire logic                   abort_o,
    input  wire logic [2:0]             mode_select_o,
    input  wire logic [2:0]             active_channel_o,
    input  wire logic                   start_conv_o,
    input  wire logic                   start_cal_o,
    input  wire chcfg_pkg::mode_flags_t mode_flags_o,
    input  wire logic                   pair_read_o
);
    import chcfg_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_mode_wr;
        req_i.wr && req_i.addr[5:3] == BLOCK_SEL_MODE;
    endsequence
    sequence s_mode_acted;
        clear_status_o && abort_o && ready_n_o;
    endsequence
    property p_mode_clears;
        s_mode_wr |=> s_mode_acted;
    endproperty
    property p_mode_target;
        s_mode_wr |=> mode_select_o == $past(req_i.wdata[7:5])
            && active_channel_o == $past(req_i.addr[2:0]);
    endproperty
    property p_conv_start;
        s_mode_wr ##0 (req_i.wdata[7:5] inside {MODE_CONT, MODE_SINGLE})
            |=> start_conv_o && !start_cal_o;
    endproperty
    property p_cal_start;
        s_mode_wr ##0 (req_i.wdata[7:5] inside {MODE_ADC_ZS, MODE_CH_ZS, MODE_CH_FS})
            |=> start_cal_o && !start_conv_o;
    endproperty
    property p_no_start;
        s_mode_wr ##0 (req_i.wdata[7:5] inside {MODE_IDLE, MODE_STANDBY, MODE_RESERVED})
            |=> !start_conv_o && !start_cal_o;
    endproperty
    // flags settle two cycles after the write
    property p_flags;
        s_mode_wr |-> ##2 mode_flags_o.data_width == ($past(req_i.wdata[1], 2) ? WIDTH_24
            : WIDTH_16) && mode_flags_o.clock_output_off == $past(req_i.wdata[4], 2);
    endproperty
    property p_pair_clamp;
        s_mode_wr |-> ##2 pair_read_o == (|$past(req_i.wdata[3:2], 2))
            && mode_flags_o.clamp == $past(req_i.wdata[0], 2);
    endproperty
    property p_read;
        req_i.rd |=> rvalid_o;
    endproperty
    property p_unmapped;
        req_i.rd && req_i.addr < SETUP_BASE |=> rdata_o == 8'h00;
    endproperty
    a_mode_clears: assert property (p_mode_clears) else $error("mode write no clear");
    a_mode_target: assert property (p_mode_target) else $error("mode or channel wrong");
    a_conv_start: assert property (p_conv_start) else $error("no conversion start");
    a_cal_start: assert property (p_cal_start) else $error("no calibration start");
    a_no_start: assert property (p_no_start) else $error("unexpected start");
    a_flags: assert property (p_flags) else $error("width or clock flag wrong");
    a_pair_clamp: assert property (p_pair_clamp) else $error("pair or clamp wrong");
    a_read: assert property (p_read) else $error("read not answered");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule : chcfg_regs_chk
bind chcfg_regs chcfg_regs_chk u_chk (.clk_i, .rst_i, .req_i, .rdata_o, .rvalid_o, .ready_n_o,
    .clear_status_o, .abort_o, .mode_select_o, .active_channel_o, .start_conv_o, .start_cal_o,
    .mode_flags_o, .pair_read_o);
`default_nettype wire

// file: chcfg_host.sv
// host model: single-byte register writes and reads
// assumes the bank answers a read one cycle after taking it
`timescale 1ns/1ns
`default_nettype none
module chcfg_host
(
    input  wire logic                clk_i,
    input  wire logic                rvalid_i,
    input  wire logic [7:0]          rdata_i,
    output var chcfg_pkg::reg_req_t  req_o
);
    import chcfg_pkg::*;
    initial req_o = '0;
    // idle fields inverted so stale values never look valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
        logic [5:0] ra;
        ra = (a[5:3] == BLOCK_SEL_MODE) ? MODE_BASE : a;
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: ra, wdata: 8'h00};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~ra, wdata: 8'hff};
        #1;
        ok = rvalid_i;
        d = rdata_i;
    endtask : rd
endmodule : chcfg_host
`default_nettype wire

// file: test_adc_channel_config_mode_regs.sv
// self-checking bench for the channel config and mode register bank
// assumes the host model is the only driver of the register port
`timescale 1ns/1ns
`default_nettype none
module test_adc_channel_config_mode_regs;
    import chcfg_pkg::*;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    reg_req_t        req_i;
    logic            general_pin_one_i = 1'b0;
    logic [7:0]      ready_flags_i = 8'h00;
    logic            conv_done_i = 1'b0;
    logic            cal_done_i = 1'b0;
    logic [7:0]      rdata_o, scan_enable_o;
    logic [2:0]      mode_select_o, active_channel_o;
    logic            rvalid_o, ready_n_o, clear_status_o, abort_o;
    logic            start_conv_o, start_cal_o, pin_or_ready_o, pair_read_o;
    ch_cfg_t         active_cfg_o;
    mode_flags_t     mode_flags_o;
    int              err_count = 0;
    int              check_count = 0;
    always #5 clk_i = ~clk_i;
    chcfg_host host (.clk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o), .req_o(req_i));
    chcfg_regs dut (.clk_i, .rst_i, .req_i, .general_pin_one_i, .ready_flags_i,
        .conv_done_i, .cal_done_i, .rdata_o, .rvalid_o, .ready_n_o,
        .clear_status_o, .abort_o, .mode_select_o, .active_channel_o, .scan_enable_o,
        .start_conv_o, .start_cal_o, .pin_or_ready_o, .active_cfg_o, .mode_flags_o,
        .pair_read_o);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        chk("rvalid", 16'h1, {15'h0, ok});
        chk("rdata", {8'h00, e}, {8'h00, d});
    endtask : rdchk
    // one done pulse; ready must fall so a later mode write can show it rise
    task automatic pulse_done(input logic cal);
        @(posedge clk_i);
        conv_done_i <= !cal;
        cal_done_i  <= cal;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        cal_done_i  <= 1'b0;
        #1;
        chk("ready_n", 16'h0, {15'h0, ready_n_o});
    endtask : pulse_done
    task automatic w3;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : w3
    task automatic mode(input logic [2:0] ch, input logic [7:0] v);
        host.wr({BLOCK_SEL_MODE, ch}, v);
        chk("acted", 16'h7, {clear_status_o, abort_o, ready_n_o});
        chk("channel", ch, active_channel_o);
        chk("start", {v[7:5] == MODE_CONT || v[7:5] == MODE_SINGLE, v[7] && v[7:5] != MODE_RESERVED},
            {start_conv_o, start_cal_o});
        w3();
        chk("mode", v[7:5], mode_select_o);
    endtask : mode
    task automatic t_defaults;
        for (int c = 0; c < 8; c++)
        begin
            rdchk({BLOCK_SEL_SETUP, c[2:0]}, SETUP_RESET);
            rdchk({BLOCK_SEL_CTIME, c[2:0]}, CTIME_RESET);
        end
        rdchk(MODE_BASE, MODE_RESET);
        chk("ready_n", 16'h1, ready_n_o);
        $display("defaults done");
    endtask : t_defaults
    task automatic t_regs;
        for (int c = 0; c < 8; c++)
        begin
            host.wr({BLOCK_SEL_SETUP, c[2:0]}, {c[2:0], 5'h1a});
            host.wr({BLOCK_SEL_CTIME, c[2:0]}, {~c[2:0], 5'h05});
        end
        host.wr(6'h05, 8'hff);
        rdchk(6'h05, 8'h00);
        rdchk(6'h27, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            rdchk({BLOCK_SEL_SETUP, c[2:0]}, {c[2:0], 5'h1a});
            rdchk({BLOCK_SEL_CTIME, c[2:0]}, {~c[2:0], 5'h05});
        end
        $display("registers done");
    endtask : t_regs
    task automatic t_modes;
        for (int m = 0; m < 8; m++)
        begin
            mode(m[2:0], {m[2:0], 5'h00});
            rdchk({BLOCK_SEL_MODE, m[2:0]}, {m[2:0], 5'h00});
        end
        for (int b = 0; b < 5; b++)
        begin
            mode(3'd0, 8'h01 << b);
            chk("flags", {b == 4, b == 3, b == 2, b == 1 ? WIDTH_24 : WIDTH_16, b == 0},
                mode_flags_o);
            chk("pair", b == 2 || b == 3, pair_read_o);
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_status;
        host.wr({BLOCK_SEL_SETUP, 3'd2}, 8'h10);
        mode(3'd2, 8'h00);
        @(posedge clk_i);
        general_pin_one_i <= 1'b1;
        w3();
        chk("pin", 16'h1, pin_or_ready_o);
        host.wr({BLOCK_SEL_SETUP, 3'd2}, 8'h00);
        @(posedge clk_i);
        ready_flags_i <= 8'h04;
        general_pin_one_i <= 1'b0;
        w3();
        chk("ready", 16'h1, pin_or_ready_o);
        @(posedge clk_i);
        ready_flags_i <= 8'hfb;
        general_pin_one_i <= 1'b1;
        w3();
        chk("ready", 16'h0, pin_or_ready_o);
        $display("status option done");
    endtask : t_status
    task automatic t_conv;
        for (int c = 0; c < 8; c++)
            host.wr({BLOCK_SEL_SETUP, c[2:0]}, (c == 3 || c == 4) ? 8'h08 : 8'h00);
        host.wr({BLOCK_SEL_CTIME, 3'd3}, 8'h82);
        mode(3'd3, {MODE_SINGLE, 5'h00});
        chk("cycles", 16'(2 * 128 + 248), active_cfg_o.conv_cycles);
        chk("chop", 16'h1, active_cfg_o.chop);
        chk("word", 16'h0082, {active_cfg_o.filter_word_ok, active_cfg_o.filter_word});
        chk("scan", 16'h18, scan_enable_o);
        pulse_done(1'b0);
        host.wr({BLOCK_SEL_CTIME, 3'd3}, 8'h7f);
        w3();
        chk("cycles", 16'(127 * 64 + 206), active_cfg_o.conv_cycles);
        chk("chop", 16'h0, active_cfg_o.chop);
        mode(3'd3, {MODE_CONT, 5'h00});
        chk("cycles", 16'(127 * 64 + 207), active_cfg_o.conv_cycles);
        host.wr({BLOCK_SEL_CTIME, 3'd3}, 8'h82);
        w3();
        chk("cycles", 16'(2 * 128 + 249), active_cfg_o.conv_cycles);
        mode(3'd3, {MODE_CH_FS, 5'h00});
        pulse_done(1'b1);
        mode(3'd3, {MODE_IDLE, 5'h00});
        $display("conversion time done");
    endtask : t_conv
    task automatic t_range;
        mode(3'd5, 8'h00);
        for (int r = 0; r < 6; r++)
        begin
            host.wr({BLOCK_SEL_SETUP, 3'd5}, {3'b011, 2'b00, r[2:0]});
            w3();
            chk("range", {!r[0], r[2] ? 2'd0 : (r[1] ? 2'd2 : 2'd1)},
                {active_cfg_o.bipolar, active_cfg_o.range_step});
            chk("pairs", {1'b1, 3'd2, 3'd3}, {active_cfg_o.differential,
                active_cfg_o.pos_input, active_cfg_o.neg_input});
        end
        host.wr({BLOCK_SEL_SETUP, 3'd5}, 8'h80);
        w3();
        chk("single", {1'b1, 1'b0, 3'd5, 1'b1}, {active_cfg_o.buf_off,
            active_cfg_o.differential, active_cfg_o.pos_input,
            active_cfg_o.neg_is_common});
        $display("range done");
    endtask : t_range
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_defaults();
        t_regs();
        t_modes();
        t_status();
        t_conv();
        t_range();
        tally_and_finish();
    end
endmodule : test_adc_channel_config_mode_regs
`default_nettype wire
